// File: rtl/dual_stack_controller.sv
// Dual stack controller: core top registers, two stack sections, register port
`timescale 1ns/1ps
// Functional notes
// - Operand stack holds 258 entries of 16 bits; top two in core registers.
// - Operand entries below the two core ones live in a 256-word RAM.
// - Return stack holds 257 entries of 21 bits; top in index register.
// - Return address occupies entry bits 1 to 19.
// - Bit 0 marks interrupt return (1); such a return re-enables interrupts.
// - Entry bit 20 saves the data page select bit.
// - Loop values moved through the return stack use bits 0 to 15.
// - Interrupt, call or loop push loads bits 16 to 19 from code page and bit 20 from data page select.
// - Two identical sections serve operand and return stacks.
// - Each section has a software 8-bit pointer and 8-bit limit.
// - Pointers form one 16-bit word, limits another.
// - Pointer word is read and write; limit word is write only.
// - Bits 0 to 7 belong to operand stack, 8 to 15 to return stack.
// - Controller requests interrupts on overflow or underflow of either stack.
// - Stack RAM access runs alongside, independent of, the data buses.
// - Push writes above pointer then increments; pop reads then decrements; wrap 256.
// - Reset clears both pointers, so the first push writes location one.
// - Overflow request while pointer exceeds limit.
// - Underflow request on pop from location one or push wrapping to zero.
module dual_stack_controller
  import dual_stack_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic opPush,
  input wire logic opPop,
  input wire logic [15:0] opPushData,
  output logic [15:0] operandTop,
  output logic [15:0] operandNext,
  input wire logic rsInt,
  input wire logic rsCall,
  input wire logic rsLoopPush,
  input wire logic rsPop,
  input wire logic [15:1] retAddrLow,
  input wire logic [15:0] loopData,
  input wire logic [3:0] codePage,
  input wire logic dataPageSel,
  output logic [20:0] retIndex,
  output logic [19:1] retAddr,
  output logic [15:0] retLoopValue,
  output logic retDataPage,
  output logic intReenable,
  input wire logic [1:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  output logic opOvfIrq,
  output logic opUnfIrq,
  output logic retOvfIrq,
  output logic retUnfIrq
);

  // ==========================================================================
  // Declarations
  logic [15:0] operandTop_r;
  logic [15:0] operandNext_r;
  logic [20:0] retIndex_r;
  logic [20:0] retIndex_nxt;
  logic intReenable_r;
  logic [15:0] regRdData_r;
  logic [15:0] regRdData_nxt;
  logic [15:0] opRamOut;
  logic [20:0] retRamOut;
  logic [7:0] opPtr;
  logic [7:0] retPtr;
  logic ptrPairWr;
  logic limitPairWr;
  logic retPush;
  logic retPopNow;
  rs_op_e rsOp;

  // ==========================================================================
  // Register decode
  assign ptrPairWr = regWr && (regAddr == REG_PTR_PAIR);
  assign limitPairWr = regWr && (regAddr == REG_LIMIT_PAIR);

  // ==========================================================================
  // Operand stack: top and next in core registers, rest in the section RAM
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      operandTop_r <= READ_ZERO;
      operandNext_r <= READ_ZERO;
    end
    else if (opPush)
    begin
      operandTop_r <= opPushData;
      operandNext_r <= operandTop_r;
    end
    else if (opPop)
    begin
      operandTop_r <= operandNext_r;
      operandNext_r <= opRamOut;
    end
  end

  assign operandTop = operandTop_r;
  assign operandNext = operandNext_r;

  // Operand section; spills next into RAM, has its own port so it never
  // waits on memory or application bus traffic
  stack_section #(
    .WIDTH(OPERAND_WIDTH),
    .DEPTH(1 << PTR_WIDTH)
  ) u_operand_section (
    .sys_clk(sys_clk),
    .reset(reset),
    .push(opPush),
    .pop(opPop && !opPush),
    .pushData(operandNext_r),
    .popData(opRamOut),
    .ptrWr(ptrPairWr),
    .ptrWrData(regWrData[7:0]),
    .limitWr(limitPairWr),
    .limitWrData(regWrData[7:0]),
    .ptr(opPtr),
    .ovfReq(opOvfIrq),
    .unfReq(opUnfIrq)
  );

  // ==========================================================================
  // Return stack operation select; interrupt outranks call, loop and pop
  always_comb
  begin
    if (rsInt)
      rsOp = RS_INT;
    else if (rsCall)
      rsOp = RS_CALL;
    else if (rsLoopPush)
      rsOp = RS_LOOP;
    else if (rsPop)
      rsOp = RS_POP;
    else
      rsOp = RS_NONE;
  end

  assign retPush = (rsOp == RS_INT) || (rsOp == RS_CALL) || (rsOp == RS_LOOP);
  assign retPopNow = (rsOp == RS_POP);

  // Next index value, with page bits from code page and data page select
  always_comb
  begin
    retIndex_nxt = retIndex_r;
    case (rsOp)
      RS_INT: retIndex_nxt = {dataPageSel, codePage, retAddrLow, RET_KIND_INT};
      RS_CALL: retIndex_nxt = {dataPageSel, codePage, retAddrLow, RET_KIND_SUB};
      RS_LOOP: retIndex_nxt = {dataPageSel, codePage, loopData};
      RS_POP: retIndex_nxt = retRamOut;
      default: retIndex_nxt = retIndex_r;
    endcase
  end

  // Index register holds the return stack top
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      retIndex_r <= '0;
    else
      retIndex_r <= retIndex_nxt;
  end

  // Returning through an interrupt-type entry re-enables interrupts
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      intReenable_r <= 1'b0;
    else
      intReenable_r <= retPopNow && (retIndex_r[RET_KIND_BIT] == RET_KIND_INT);
  end

  assign retIndex = retIndex_r;
  assign retAddr = retIndex_r[RET_ADDR_MSB:RET_ADDR_LSB];
  assign retLoopValue = retIndex_r[RET_LOOP_MSB:0];
  assign retDataPage = retIndex_r[RET_DPS_BIT];
  assign intReenable = intReenable_r;

  // Return section, identical in structure to the operand one
  stack_section #(
    .WIDTH(RETURN_WIDTH),
    .DEPTH(1 << PTR_WIDTH)
  ) u_return_section (
    .sys_clk(sys_clk),
    .reset(reset),
    .push(retPush),
    .pop(retPopNow),
    .pushData(retIndex_r),
    .popData(retRamOut),
    .ptrWr(ptrPairWr),
    .ptrWrData(regWrData[15:8]),
    .limitWr(limitPairWr),
    .limitWrData(regWrData[15:8]),
    .ptr(retPtr),
    .ovfReq(retOvfIrq),
    .unfReq(retUnfIrq)
  );

  // ==========================================================================
  // Register read: pointer pair, write-only limit reads zero, status
  always_comb
  begin
    regRdData_nxt = READ_ZERO;
    if (regAddr == REG_PTR_PAIR)
      regRdData_nxt = pack_pair(opPtr, retPtr);
    else if (regAddr == REG_LIMIT_PAIR)
      regRdData_nxt = READ_ZERO;
    else if (regAddr == REG_STATUS)
    begin
      regRdData_nxt[ST_OP_OVF] = opOvfIrq;
      regRdData_nxt[ST_OP_UNF] = opUnfIrq;
      regRdData_nxt[ST_RET_OVF] = retOvfIrq;
      regRdData_nxt[ST_RET_UNF] = retUnfIrq;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      regRdData_r <= READ_ZERO;
    else if (regRd)
      regRdData_r <= regRdData_nxt;
    else
      regRdData_r <= READ_ZERO;
  end

  assign regRdData = regRdData_r;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  property p_op_push_shift;
    opPush |=> (operandTop == $past(opPushData)) && (operandNext == $past(operandTop));
  endproperty
  a_op_push_shift: assert property (p_op_push_shift) else $error("operand push did not shift top");

  property p_op_push_pop_restore;
    (opPush && !opPop && !ptrPairWr) ##1 (opPop && !opPush && !ptrPairWr)
      |=> (operandTop == $past(operandTop, 2)) && (operandNext == $past(operandNext, 2));
  endproperty
  a_op_push_pop_restore: assert property (p_op_push_pop_restore) else $error("push then pop lost data");

  property p_op_ptr_inc;
    (opPush && !ptrPairWr) |=> (opPtr == 8'($past(opPtr) + PTR_STEP));
  endproperty
  a_op_ptr_inc: assert property (p_op_ptr_inc) else $error("operand pointer did not increment");

  property p_ret_ptr_dec;
    (retPopNow && !ptrPairWr) |=> (retPtr == 8'($past(retPtr) - PTR_STEP));
  endproperty
  a_ret_ptr_dec: assert property (p_ret_ptr_dec) else $error("return pointer did not decrement");

  property p_call_format;
    (rsOp == RS_CALL) |=> (retIndex[RET_KIND_BIT] == RET_KIND_SUB)
      && (retIndex[RET_PAGE_MSB:RET_PAGE_LSB] == $past(codePage))
      && (retIndex[RET_DPS_BIT] == $past(dataPageSel)) && (retAddr[15:1] == $past(retAddrLow));
  endproperty
  a_call_format: assert property (p_call_format) else $error("call entry misformatted");

  property p_int_return;
    (rsOp == RS_INT) ##1 (rsOp == RS_POP) |=> intReenable;
  endproperty
  a_int_return: assert property (p_int_return) else $error("interrupt return did not re-enable");

  property p_sub_return;
    (retPopNow && !retIndex[RET_KIND_BIT]) |=> !intReenable;
  endproperty
  a_sub_return: assert property (p_sub_return) else $error("subroutine return re-enabled");

  property p_loop_value;
    (rsOp == RS_LOOP) |=> (retLoopValue == $past(loopData)) && (retDataPage == $past(dataPageSel));
  endproperty
  a_loop_value: assert property (p_loop_value) else $error("loop value not placed in low bits");

  property p_ptr_read;
    (regRd && regAddr == REG_PTR_PAIR) |=> (regRdData == {$past(retPtr), $past(opPtr)});
  endproperty
  a_ptr_read: assert property (p_ptr_read) else $error("pointer pair read wrong");

  property p_limit_wo;
    (regRd && regAddr == REG_LIMIT_PAIR) |=> (regRdData == READ_ZERO);
  endproperty
  a_limit_wo: assert property (p_limit_wo) else $error("limit pair is readable");

  property p_ovf_level;
    (limitPairWr && regWrData[7:0] < opPtr && !opPush && !opPop && !ptrPairWr) |=> opOvfIrq;
  endproperty
  a_ovf_level: assert property (p_ovf_level) else $error("overflow not raised above limit");

  property p_unf_pop_one;
    (opPop && !opPush && !ptrPairWr && opPtr == PTR_FIRST) |=> opUnfIrq;
  endproperty
  a_unf_pop_one: assert property (p_unf_pop_one) else $error("underflow missing after pop from one");

  property p_unf_drops;
    (opUnfIrq && opPush && !ptrPairWr) |=> !opUnfIrq;
  endproperty
  a_unf_drops: assert property (p_unf_drops) else $error("underflow held after condition cleared");

  property p_op_pop_shift;
    (opPop && !opPush) |=> (operandTop == $past(operandNext));
  endproperty
  a_op_pop_shift: assert property (p_op_pop_shift) else $error("operand pop did not lift next");

  property p_op_ptr_dec;
    (opPop && !opPush && !ptrPairWr) |=> (opPtr == 8'($past(opPtr) - PTR_STEP));
  endproperty
  a_op_ptr_dec: assert property (p_op_ptr_dec) else $error("operand pointer did not decrement");

  property p_ret_ptr_inc;
    (retPush && !ptrPairWr) |=> (retPtr == 8'($past(retPtr) + PTR_STEP));
  endproperty
  a_ret_ptr_inc: assert property (p_ret_ptr_inc) else $error("return pointer did not increment");

  property p_ptr_write;
    ptrPairWr |=> (opPtr == $past(regWrData[7:0])) && (retPtr == $past(regWrData[15:8]));
  endproperty
  a_ptr_write: assert property (p_ptr_write) else $error("pointer pair write did not land");

  property p_int_format;
    (rsOp == RS_INT) |=> (retIndex[RET_KIND_BIT] == RET_KIND_INT) && (retAddr[15:1] == $past(retAddrLow));
  endproperty
  a_int_format: assert property (p_int_format) else $error("interrupt entry misformatted");

  property p_rd_idle;
    !regRd |=> (regRdData == READ_ZERO);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data stood without a read strobe");

  c_op_wrap: cover property (opPush && opPtr == LIMIT_RESET);
  c_int_return: cover property ((rsOp == RS_INT) ##1 (rsOp == RS_POP));
  c_ovf: cover property ($rose(retOvfIrq));
  c_ptr_read: cover property (regRd && regAddr == REG_PTR_PAIR);

endmodule : dual_stack_controller

// File: rtl/dual_stack_pkg.sv
// Constants, field layout and helpers shared by the dual stack controller
package dual_stack_pkg;

  // ==========================================================================
  // Widths
  localparam int OPERAND_WIDTH = 16;
  localparam int RETURN_WIDTH = 21;
  localparam int PTR_WIDTH = 8;
  localparam int REG_ADDR_WIDTH = 2;
  localparam int PAIR_WIDTH = 16;
  localparam int CODE_PAGE_WIDTH = 4;

  // ==========================================================================
  // Register offsets on the plain register port
  localparam logic [1:0] REG_PTR_PAIR = 2'h0;
  localparam logic [1:0] REG_LIMIT_PAIR = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;

  // ==========================================================================
  // Reset values and special pointer positions
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] LIMIT_RESET = 8'hFF;
  localparam logic [7:0] PTR_BOTTOM = 8'h00;
  localparam logic [7:0] PTR_FIRST = 8'h01;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [15:0] READ_ZERO = 16'h0000;

  // ==========================================================================
  // Return stack entry fields
  localparam int RET_KIND_BIT = 0;
  localparam int RET_ADDR_LSB = 1;
  localparam int RET_ADDR_MSB = 19;
  localparam int RET_LOOP_MSB = 15;
  localparam int RET_PAGE_LSB = 16;
  localparam int RET_PAGE_MSB = 19;
  localparam int RET_DPS_BIT = 20;
  localparam logic RET_KIND_INT = 1'b1;
  localparam logic RET_KIND_SUB = 1'b0;

  // Status register bit positions
  localparam int ST_OP_OVF = 0;
  localparam int ST_OP_UNF = 1;
  localparam int ST_RET_OVF = 2;
  localparam int ST_RET_UNF = 3;

  // Return stack operation of the current cycle
  typedef enum logic [2:0] {
    RS_NONE = 3'b000,
    RS_INT = 3'b001,
    RS_CALL = 3'b010,
    RS_LOOP = 3'b011,
    RS_POP = 3'b100
  } rs_op_e;

  // Operand byte low, return byte high
  function automatic logic [15:0] pack_pair(input logic [7:0] opByte, input logic [7:0] retByte);
    pack_pair = {retByte, opByte};
  endfunction : pack_pair

endpackage : dual_stack_pkg

// File: rtl/stack_section.sv
// One stack section: RAM, pointer, limit and error requests
`timescale 1ns/1ps
module stack_section
  import dual_stack_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 256
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] pushData,
  output logic [WIDTH-1:0] popData,
  input wire logic ptrWr,
  input wire logic [7:0] ptrWrData,
  input wire logic limitWr,
  input wire logic [7:0] limitWrData,
  output logic [7:0] ptr,
  output logic ovfReq,
  output logic unfReq
);

  // ==========================================================================
  // Elaboration check: the pointer is eight bits wide
  if (DEPTH != (1 << PTR_WIDTH))
  begin : g_depth_check
    $error("stack_section: DEPTH must equal 256");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [7:0] ptr_r;
  logic [7:0] limit_r;
  logic used_r;
  logic [7:0] pushAddr;

  assign ptr = ptr_r;
  assign pushAddr = ptr_r + PTR_STEP;

  // ==========================================================================
  // Pointer: pre-increment push, post-decrement pop, wraps modulo 256
  // A pointer write wins over the stack operation of the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      ptr_r <= PTR_RESET;
    else if (ptrWr)
      ptr_r <= ptrWrData;
    else if (push)
      ptr_r <= pushAddr;
    else if (pop)
      ptr_r <= ptr_r - PTR_STEP;
  end

  // Limit register, write only from software
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      limit_r <= LIMIT_RESET;
    else if (limitWr)
      limit_r <= limitWrData;
  end

  // RAM write goes to the location above the old pointer
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[pushAddr] <= pushData;
  end

  // Pop reads the location at the pointer in the same cycle
  assign popData = mem[ptr_r];

  // Tracks that the stack has moved since reset, so reset zero is no error
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      used_r <= 1'b0;
    else if (push || pop)
      used_r <= 1'b1;
  end

  // Level requests recomputed from pointer and limit every cycle
  assign ovfReq = (ptr_r > limit_r);
  assign unfReq = used_r && (ptr_r == PTR_BOTTOM);

endmodule : stack_section

// File: testbench/core_model.sv
// Processor core model that issues stack requests to the controller
`timescale 1ns/1ps
module core_model
(
  input wire logic sys_clk,
  output logic opPush,
  output logic opPop,
  output logic [15:0] opPushData,
  output logic rsInt,
  output logic rsCall,
  output logic rsLoopPush,
  output logic rsPop,
  output logic [15:1] retAddrLow,
  output logic [15:0] loopData,
  output logic [3:0] codePage,
  output logic dataPageSel
);
  // ==========================================================================
  // Idle state at time zero
  initial
  begin
    {opPush, opPop, rsInt, rsCall, rsLoopPush, rsPop} = 6'h00;
    opPushData = 16'h0000;
    loopData = 16'h0000;
    retAddrLow = 15'h0000;
    {dataPageSel, codePage} = 5'h00;
  end

  // ==========================================================================
  // One request cycle; data lines then show the inverse, not a stale value
  task automatic go(input logic [5:0] req, input logic [4:0] pg, input logic [15:0] d);
    @(posedge sys_clk);
    {opPush, opPop, rsInt, rsCall, rsLoopPush, rsPop} <= req;
    {dataPageSel, codePage} <= pg;
    opPushData <= d;
    loopData <= d;
    retAddrLow <= d[15:1];
    @(posedge sys_clk);
    {opPush, opPop, rsInt, rsCall, rsLoopPush, rsPop} <= 6'h00;
    opPushData <= ~d;
    loopData <= ~d;
    retAddrLow <= ~d[15:1];
  endtask : go

  // Two requests on consecutive edges, for back-to-back sequences
  task automatic go2(input logic [5:0] reqA, input logic [5:0] reqB, input logic [4:0] pg, input logic [15:0] d);
    @(posedge sys_clk);
    {opPush, opPop, rsInt, rsCall, rsLoopPush, rsPop} <= reqA;
    {dataPageSel, codePage} <= pg;
    opPushData <= d;
    loopData <= d;
    retAddrLow <= d[15:1];
    @(posedge sys_clk);
    {opPush, opPop, rsInt, rsCall, rsLoopPush, rsPop} <= reqB;
    @(posedge sys_clk);
    {opPush, opPop, rsInt, rsCall, rsLoopPush, rsPop} <= 6'h00;
    opPushData <= ~d;
    loopData <= ~d;
    retAddrLow <= ~d[15:1];
  endtask : go2
endmodule : core_model

// File: testbench/tb_dual_stack_controller.sv
// Self-checking bench for the dual stack controller
`timescale 1ns/1ps
module tb_dual_stack_controller;
  import dual_stack_pkg::*;
  // ==========================================================================
  // Request codes and signals
  localparam logic [5:0] PUSH = 6'h20;
  localparam logic [5:0] POP = 6'h10;
  localparam logic [5:0] RINT = 6'h08;
  localparam logic [5:0] RCALL = 6'h04;
  localparam logic [5:0] RLOOP = 6'h02;
  localparam logic [5:0] RPOP = 6'h01;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic opPush, opPop, rsInt, rsCall, rsLoopPush, rsPop, dataPageSel, retDataPage, intReenable;
  logic regWr, regRd, opOvfIrq, opUnfIrq, retOvfIrq, retUnfIrq;
  logic [15:0] opPushData, loopData, operandTop, operandNext, regWrData, regRdData, retLoopValue;
  logic [15:1] retAddrLow;
  logic [3:0] codePage;
  logic [20:0] retIndex;
  logic [19:1] retAddr;
  logic [1:0] regAddr;
  int badCount = 0;
  int checksDone = 0;

  // ==========================================================================
  // Clock, core model and design
  always #10 sys_clk = ~sys_clk;

  core_model core (.sys_clk, .opPush, .opPop, .opPushData, .rsInt, .rsCall, .rsLoopPush, .rsPop,
    .retAddrLow, .loopData, .codePage, .dataPageSel);

  dual_stack_controller DUT (.sys_clk, .reset, .opPush, .opPop, .opPushData, .operandTop, .operandNext,
    .rsInt, .rsCall, .rsLoopPush, .rsPop, .retAddrLow, .loopData, .codePage, .dataPageSel, .retIndex,
    .retAddr, .retLoopValue, .retDataPage, .intReenable, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .opOvfIrq, .opUnfIrq, .retOvfIrq, .retUnfIrq);

  // ==========================================================================
  // Compare, register access and stack request tasks
  task automatic chk(input string n, input logic [20:0] seen, input logic [20:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      badCount++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input string n, input logic [1:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    chk(n, regRdData, exp);
  endtask : rd

  task automatic op(input logic [5:0] req, input logic [4:0] pg, input logic [15:0] d);
    core.go(req, pg, d);
    #1;
  endtask : op

  task automatic op2(input logic [5:0] reqA, input logic [5:0] reqB, input logic [4:0] pg, input logic [15:0] d);
    core.go2(reqA, reqB, pg, d);
    #1;
  endtask : op2

  task automatic irq(input logic [3:0] exp);
    chk("irq", {opOvfIrq, opUnfIrq, retOvfIrq, retUnfIrq}, exp);
  endtask : irq

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  // ==========================================================================
  // Watchdog
  initial
  begin
    #40000;
    badCount++;
    report_and_stop();
  end

  // ==========================================================================
  // Test sequence
  initial
  begin
    regAddr = 2'h0;
    regWrData = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    // Reset state, write-only limits, unmapped address
    rd("ptr", REG_PTR_PAIR, 16'h0000);
    rd("lim", REG_LIMIT_PAIR, 16'h0000);
    rd("unmapped", 2'h3, 16'h0000);
    irq(4'h0);
    // Four pushes, then pops down through location one
    op(PUSH, 5'h00, 16'h1111);
    op(PUSH, 5'h00, 16'h2222);
    op(PUSH, 5'h00, 16'h3333);
    op(PUSH, 5'h00, 16'h4444);
    chk("top", operandTop, 16'h4444);
    chk("next", operandNext, 16'h3333);
    rd("ptr", REG_PTR_PAIR, 16'h0004);
    op(POP, 5'h00, 16'h0000);
    op(POP, 5'h00, 16'h0000);
    chk("top", operandTop, 16'h2222);
    chk("next", operandNext, 16'h1111);
    op(POP, 5'h00, 16'h0000);
    irq(4'h0);
    op(POP, 5'h00, 16'h0000);
    chk("top", operandTop, 16'h0000);
    irq(4'h4);
    op(PUSH, 5'h00, 16'h5555);
    irq(4'h0);
    // Limits: operand 1, return 2
    wr(REG_LIMIT_PAIR, 16'h0201);
    rd("lim", REG_LIMIT_PAIR, 16'h0000);
    op(PUSH, 5'h00, 16'h6666);
    irq(4'h8);
    rd("status", REG_STATUS, 16'h0001);
    op(POP, 5'h00, 16'h0000);
    irq(4'h0);
    // Pointer write, then a push that wraps to location zero
    wr(REG_PTR_PAIR, 16'h00FF);
    rd("ptr", REG_PTR_PAIR, 16'h00FF);
    op(PUSH, 5'h00, 16'h7777);
    chk("opunf", opUnfIrq, 1'b1);
    rd("ptr", REG_PTR_PAIR, 16'h0000);
    // Return stack: call, interrupt and loop entries
    op(RCALL, 5'h05, 16'h0246);
    chk("ridx", retIndex, 21'h050246);
    chk("raddr", retAddr, 19'h28123);
    op(RINT, 5'h1A, 16'h1234);
    chk("ridx", retIndex, 21'h1A1235);
    chk("rdps", retDataPage, 1'b1);
    op(RLOOP, 5'h03, 16'hBEE2);
    chk("ridx", retIndex, 21'h03BEE2);
    chk("rloop", retLoopValue, 16'hBEE2);
    chk("rovf", retOvfIrq, 1'b1);
    rd("ptr", REG_PTR_PAIR, 16'h0300);
    op(RPOP, 5'h03, 16'h0000);
    chk("ridx", retIndex, 21'h1A1235);
    chk("reen", intReenable, 1'b0);
    chk("rovf", retOvfIrq, 1'b0);
    op(RPOP, 5'h03, 16'h0000);
    chk("ridx", retIndex, 21'h050246);
    chk("reen", intReenable, 1'b1);
    op(RPOP, 5'h03, 16'h0000);
    chk("runf", retUnfIrq, 1'b1);
    // Push and pop together act as a push
    op(PUSH | POP, 5'h03, 16'h8888);
    chk("top", operandTop, 16'h8888);
    chk("next", operandNext, 16'h7777);
    rd("ptr", REG_PTR_PAIR, 16'h0001);
    // Back-to-back push then pop leaves the operand stack as it was
    op2(PUSH, POP, 5'h00, 16'h9999);
    chk("top", operandTop, 16'h8888);
    chk("next", operandNext, 16'h7777);
    irq(4'h1);
    // Operand limit written below the pointer raises overflow at once
    wr(REG_LIMIT_PAIR, 16'h0200);
    rd("status", REG_STATUS, 16'h0009);
    // Interrupt entry popped on the very next cycle re-enables interrupts
    op2(RINT, RPOP, 5'h00, 16'h0100);
    chk("ridx", retIndex, 21'h000000);
    chk("reen", intReenable, 1'b1);
    report_and_stop();
  end
endmodule : tb_dual_stack_controller
